// ==== hdl/flash_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_defs.svh"
module flash_host (
    // Clock and reset.
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // User request port.
    input  wire logic                     req_valid,
    input  wire logic                     req_write,
    input  wire logic [21:0]              req_addr,
    input  wire logic [15:0]              req_wdata,
    input  wire logic                     req_byte,
    input  wire logic                     req_reset,
    output logic                          req_ready,
    output logic                          rsp_valid,
    output logic [15:0]                   rsp_rdata,
    output logic [1:0]                    rsp_bank,
    output logic                          rsp_small_sector,
    output logic                          flash_busy,
    // Flash pins.
    output flash_host_pkg::flash_ctl_s    ctl,
    output logic                          byte_addr_lsb,
    input  wire logic [15:0]              dq_in,
    output logic [15:0]                   dq_out,
    output logic                          dq_oe,
    input  wire logic                     ready_busy_n
);
    import flash_host_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [15:0] dq_s1_r, dq_s2_r;
    logic        rb_s1_r, rb_s2_r;
    // Two stages keep metastability off the capture path.
    always_ff @(posedge core_clk) begin
        dq_s1_r <= dq_in;
        dq_s2_r <= dq_s1_r;
        rb_s1_r <= ready_busy_n;
        rb_s2_r <= rb_s1_r;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    host_state_e state_r, state_nxt;
    logic [7:0]  cnt_r, cnt_nxt;
    flash_ctl_s  ctl_r, ctl_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic        lsb_r, lsb_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        rsp_r, rsp_nxt;
    logic        req_byte_r;
    logic [1:0]  bank_r;
    logic        small_r;

    wire cnt_done = (cnt_r == 8'h00);
    wire idle     = (state_r == ST_IDLE);
    // Bank and sector decode of the request address.
    wire [1:0] req_bank_w  = req_addr[`BANK_MSB:`BANK_LSB];
    wire       small_sec_w = (req_addr <= `SMALL_SECT_END) ;

    assign req_ready = idle && !req_reset;

    // Next-state logic drives the pins level by level per bus cycle.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_done ? 8'h00 : cnt_r - 8'h01;
        ctl_nxt   = ctl_r;
        wdata_nxt = wdata_r;
        lsb_nxt   = lsb_r;
        rdata_nxt = rdata_r;
        rsp_nxt   = 1'b0;
        case (state_r)
            ST_RESET: begin
                ctl_nxt.reset_n         = 1'b0;
                ctl_nxt.chip_select_n   = 1'b1;
                ctl_nxt.output_enable_n = 1'b1;
                ctl_nxt.write_enable_n  = 1'b1;
                if (cnt_done) begin
                    ctl_nxt.reset_n = 1'b1;
                    cnt_nxt   = 8'(`T_RECOVERY_CYC);
                    state_nxt = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // Wait recovery and busy release before any access.
                // Requests stay refused until then, so the user can only
                // re-issue an interrupted sequence once the device is ready.
                if (cnt_done && rb_s2_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req_reset) begin
                    // Pull the pin low at once so the pulse counts from
                    // the edge that takes the request.
                    ctl_nxt.reset_n = 1'b0;
                    cnt_nxt   = 8'(`T_RESET_PULSE_CYC);
                    state_nxt = ST_RESET;
                end else if (req_valid) begin
                    ctl_nxt.addr          = req_addr;
                    ctl_nxt.width_select  = !req_byte;
                    lsb_nxt               = req_addr[0] & req_byte;
                    ctl_nxt.chip_select_n = 1'b0;
                    wdata_nxt             = req_wdata;
                    if (req_write) begin
                        ctl_nxt.write_enable_n  = 1'b0;
                        ctl_nxt.output_enable_n = 1'b1;
                        // One request is one bus cycle, so a bypass
                        // program costs the user two requests.
                        cnt_nxt   = 8'(`T_WRITE_PULSE_CYC);
                        state_nxt = ST_WRITE;
                    end else begin
                        ctl_nxt.output_enable_n = 1'b0;
                        ctl_nxt.write_enable_n  = 1'b1;
                        // Full access time plus sync latency covers
                        // standby exit as well.
                        cnt_nxt   = 8'(`T_ACCESS_CYC + 2);
                        state_nxt = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (cnt_done) begin
                    rdata_nxt = req_byte_r ? {8'h00, dq_s2_r[7:0]}
                                           : dq_s2_r;
                    rsp_nxt   = 1'b1;
                    ctl_nxt.output_enable_n = 1'b1;
                    ctl_nxt.chip_select_n   = 1'b1;
                    state_nxt = ST_GAP;
                end
            end
            ST_WRITE: begin
                if (cnt_done) begin
                    ctl_nxt.write_enable_n = 1'b1;
                    ctl_nxt.chip_select_n  = 1'b1;
                    rsp_nxt   = 1'b1;
                    state_nxt = ST_GAP;
                end
            end
            ST_GAP: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Reset pulses the flash too, so the device starts in read-array mode.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= ST_RESET;
            cnt_r   <= 8'(`T_RESET_PULSE_CYC);
            ctl_r   <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 22'h000000};
            wdata_r <= 16'h0000;
            lsb_r   <= 1'b0;
            rdata_r <= 16'h0000;
            rsp_r   <= 1'b0;
            req_byte_r <= 1'b0;
            bank_r  <= 2'h0;
            small_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            ctl_r   <= ctl_nxt;
            wdata_r <= wdata_nxt;
            lsb_r   <= lsb_nxt;
            rdata_r <= rdata_nxt;
            rsp_r   <= rsp_nxt;
            if (idle && req_valid && !req_reset) begin
                req_byte_r <= req_byte;
                bank_r     <= req_bank_w;
                small_r    <= small_sec_w;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every control pin comes from a register at all times, so none floats.
    assign ctl              = ctl_r;
    // Data bus is driven only during write cycles so it never fights
    // the device during reads.
    assign byte_addr_lsb    = lsb_r;
    assign dq_out           = wdata_r;
    assign dq_oe            = (state_r == ST_WRITE);
    assign rsp_valid        = rsp_r;
    assign rsp_rdata        = rdata_r;
    assign rsp_bank         = bank_r;
    assign rsp_small_sector = small_r;
    // Busy is a level; a new access to another bank is still allowed.
    assign flash_busy       = !rb_s2_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_read_levels: assert property (
        @(posedge core_clk) disable iff (rst)
        state_r == ST_READ |-> !ctl_r.chip_select_n && !ctl_r.output_enable_n
                               && ctl_r.write_enable_n)
        else $error("read cycle pin levels wrong");
    chk_write_levels: assert property (
        @(posedge core_clk) disable iff (rst)
        state_r == ST_WRITE |-> !ctl_r.chip_select_n && !ctl_r.write_enable_n
                                && ctl_r.output_enable_n && dq_oe)
        else $error("write cycle pin levels wrong");
    chk_no_clash: assert property (
        @(posedge core_clk) disable iff (rst)
        !ctl_r.output_enable_n |-> !dq_oe)
        else $error("host drives bus while device outputs");
    sequence reset_start;
        state_r == ST_IDLE && req_reset;
    endsequence
    chk_reset_pulse: assert property (
        @(posedge core_clk) disable iff (rst)
        reset_start |=> !ctl_r.reset_n [*8])
        else $error("reset pulse too short");
    chk_recover_wait: assert property (
        @(posedge core_clk) disable iff (rst)
        state_r == ST_RECOVER && !rb_s2_r |=> state_r != ST_IDLE)
        else $error("left recovery while busy");
    chk_byte_lsb: assert property (
        @(posedge core_clk) disable iff (rst)
        ctl_r.width_select |-> !lsb_r)
        else $error("byte address used in word mode");
    chk_width_follow: assert property (
        @(posedge core_clk) disable iff (rst)
        idle && req_valid && !req_reset |=> ctl_r.width_select == !req_byte_r)
        else $error("width select mismatch");
    chk_read_done: assert property (
        @(posedge core_clk) disable iff (rst)
        idle && req_valid && !req_write && !req_reset
        |=> ##[1:20] rsp_valid)
        else $error("read response missing");
endmodule
`default_nettype wire

// ==== hdl/flash_host_defs.svh ====
// Function
// - Read: host drives chip select and output enable low, write high.
// - Write: host drives write enable and chip select low, output high.
// - In bypass mode a program takes two write cycles, not four.
// - Host has no high-voltage pin; bypass programming comes by command only.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH
`define CLK_PERIOD_NS      8
`define T_ACCESS_NS        70
`define T_ACCESS_CYC       ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RESET_PULSE_NS   500
`define T_RESET_PULSE_CYC  ((`T_RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RECOVERY_NS      200
`define T_RECOVERY_CYC     ((`T_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WRITE_PULSE_NS   40
`define T_WRITE_PULSE_CYC  ((`T_WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BANK_MSB           21
`define BANK_LSB           20
`define SMALL_SECT_END     22'h007fff
`endif

// ==== hdl/flash_host_pkg.sv ====
package flash_host_pkg;
    typedef enum logic [2:0] {
        ST_RESET   = 3'b000,
        ST_RECOVER = 3'b001,
        ST_IDLE    = 3'b010,
        ST_READ    = 3'b011,
        ST_WRITE   = 3'b100,
        ST_GAP     = 3'b101
    } host_state_e;

    typedef struct packed {
        logic        chip_select_n;
        logic        output_enable_n;
        logic        write_enable_n;
        logic        reset_n;
        logic        width_select;
        logic [21:0] addr;
    } flash_ctl_s;
endpackage

// ==== testbench/flash_dev_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// Pin-level model of the flash device, sampled between clock edges.
// ----
module flash_dev_model #(
    parameter logic [15:0] PROG_CMD = 16'h00a0,
    parameter logic [15:0] ID_CMD   = 16'h0090,
    parameter logic [15:0] EXIT_CMD = 16'h00f0,
    parameter logic [15:0] ID_CODE  = 16'h1234, // Arbitrary value.
    parameter logic [15:0] ERASE_CMD = 16'h0030,
    parameter int          ACC_NS   = 70,
    parameter int          BUSY_NS  = 3000,
    parameter int          READY_NS = 1000
) (
    // Pins from the host.
    input  wire flash_host_pkg::flash_ctl_s ctl,
    input  wire logic                       byte_lsb,
    input  wire logic [15:0]                dq,
    // Pins towards the host.
    output logic [15:0]                     dev_dq,
    output logic [15:0]                     dev_en,
    output logic                            ready_busy_n
);
    import flash_host_pkg::*;
    logic [15:0] mem [logic [21:0]];
    logic        id_mode;
    logic        armed;
    logic        abort;
    logic        wr_on;
    logic [21:0] wa;
    logic [15:0] wd;
    realtime     done_at;
    realtime     sel_at;
    logic        erasing;

    // Polling at odd nanoseconds keeps clear of every host clock edge.
    initial begin
        {id_mode, armed, abort, wr_on, erasing, dev_en} = '0;
        ready_busy_n = 1'b1;
        sel_at = 0.0;
        #1;
        forever begin
            if (!ctl.reset_n) begin
                {id_mode, armed, wr_on} = 3'b000;
                if (!ready_busy_n && !abort) begin
                    abort = 1'b1;
                    done_at = $realtime + READY_NS;
                end
            end else if (!ctl.chip_select_n && !ctl.write_enable_n
                         && ctl.output_enable_n) begin
                {wr_on, wa, wd} = {1'b1, ctl.addr, dq};
            end else if (wr_on) begin
                wr_on = 1'b0;
                // Bypass comes by command only; the host has no accel
                // pin, so nothing here ever drives the high voltage.
                if (armed || wd == ERASE_CMD) begin
                    erasing = !armed;
                    {armed, abort, ready_busy_n} = 3'b000;
                    done_at = $realtime + BUSY_NS;
                end else if (wd == PROG_CMD) armed = 1'b1;
                else if (wd == ID_CMD) id_mode = 1'b1;
                else if (wd == EXIT_CMD) id_mode = 1'b0;
            end
            // Deselection does not cut a running program short.
            if (!ready_busy_n && $realtime >= done_at) begin
                if (!abort && erasing) mem.delete(wa);
                else if (!abort) mem[wa] = wd;
                ready_busy_n = 1'b1;
            end
            dev_dq = mem.exists(ctl.addr) ? mem[ctl.addr]
                   : ctl.addr[15:0] ^ 16'h5a5a;
            if (id_mode) dev_dq = ID_CODE;
            if (!ctl.width_select)
                dev_dq = {8'h00, byte_lsb ? dev_dq[15:8] : dev_dq[7:0]};
            dev_en = '0;
            if (!ctl.chip_select_n && !ctl.output_enable_n
                && ctl.write_enable_n && ctl.reset_n) begin
                dev_en = ctl.width_select ? 16'hffff : 16'h00ff;
                // Data is wrong until the access time after selection.
                if ($realtime - sel_at < ACC_NS) dev_dq = ~dev_dq;
            end else sel_at = $realtime;
            #4;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/flash_host_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module flash_host_tb;
    import flash_host_pkg::*;
    localparam logic [15:0] PROG = 16'h00a0;
    localparam logic [15:0] IDC  = 16'h0090;
    localparam logic [15:0] EXIT = 16'h00f0;
    localparam logic [15:0] ERASE = 16'h0030;
    localparam logic [15:0] CODE = 16'h1234; // Arbitrary value.
    logic        core_clk = 0, rst = 1, req_valid = 0, req_write = 0;
    logic        req_byte = 0, req_reset = 0;
    logic [21:0] req_addr = '0, a, b;
    logic [15:0] req_wdata = '0, d, rsp_rdata, dq_out, dev_dq, dev_en;
    logic [15:0] dq_prev = '0;
    logic        req_ready, rsp_valid, rsp_small_sector, flash_busy;
    logic        byte_addr_lsb, dq_oe, ready_busy_n;
    logic [1:0]  rsp_bank;
    flash_ctl_s  ctl;
    wire  [15:0] dq_bus;
    int          error_cnt = 0, compares = 0, cycles = 0, n;
    int          seed = 32'h2f972b53;
    // ----
    // Bus resolution: an undriven line shows the inverse of its last level.
    // ----
    assign dq_bus = dq_oe ? dq_out : (dev_en & dev_dq) | (~dev_en & ~dq_prev);
    always @(posedge core_clk) dq_prev <= dq_bus;
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    flash_host u_dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_byte(req_byte), .req_reset(req_reset), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_bank(rsp_bank),
        .rsp_small_sector(rsp_small_sector), .flash_busy(flash_busy),
        .ctl(ctl), .byte_addr_lsb(byte_addr_lsb), .dq_in(dq_bus),
        .dq_out(dq_out), .dq_oe(dq_oe), .ready_busy_n(ready_busy_n));
    flash_dev_model u_dev (.ctl(ctl), .byte_lsb(byte_addr_lsb), .dq(dq_bus),
        .dev_dq(dev_dq), .dev_en(dev_en), .ready_busy_n(ready_busy_n));
    // ----
    // Checking helpers.
    // ----
    function automatic logic [15:0] exp_byte(logic [21:0] x);
        exp_byte = x[15:0] ^ 16'h5a5a;
        exp_byte = {8'h00, x[0] ? exp_byte[15:8] : exp_byte[7:0]};
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Strobe levels are watched whenever the host holds a cycle.
    always @(negedge core_clk) begin
        if (ctl.output_enable_n === 1'b0)
            check("read strobes", 2'b01, {ctl.chip_select_n, ctl.write_enable_n});
        if (ctl.write_enable_n === 1'b0)
            check("write strobes", 3'b011, {ctl.chip_select_n, ctl.output_enable_n, dq_oe});
    end
    task automatic idle_wait;
        for (n = 0; req_ready !== 1'b1 && n < 3000; n++) @(negedge core_clk);
        check("ready", 1, req_ready);
    endtask
    task automatic xfer(logic wr, logic bt, logic [21:0] x, logic [15:0] v);
        @(negedge core_clk);
        {req_valid, req_write, req_byte, req_addr, req_wdata} = {1'b1, wr, bt, x, v};
        idle_wait();
        @(negedge core_clk);
        req_valid = 1'b0;
        for (n = 0; rsp_valid !== 1'b1 && n < 100; n++) @(negedge core_clk);
        check("response", 1, rsp_valid);
        check("bank", x[21:20], rsp_bank);
        check("small sector", x <= 22'h007fff, rsp_small_sector);
    endtask
    task automatic rd(logic bt, logic [21:0] x, logic [15:0] e);
        xfer(0, bt, x, 16'h0000);
        check("read data", e, rsp_rdata);
    endtask
    // ----
    // Main sequence.
    // ----
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 0;
        idle_wait();
        for (int i = 0; i < 14; i++) begin
            a = i == 0 ? 22'h007fff : i == 1 ? 22'h008000 : 22'($random(seed));
            if (i == 2) a = 22'h3fffff;
            rd(0, a, a[15:0] ^ 16'h5a5a);
            rd(1, a, exp_byte(a));
        end
        $display("test reads done");
        a = 22'($random(seed));
        d = 16'($random(seed));
        xfer(1, 0, a, PROG);
        xfer(1, 0, a, d);
        rd(0, a ^ 22'h100000, a[15:0] ^ 16'h5a5a);
        check("busy", 1, flash_busy);
        for (n = 0; flash_busy !== 1'b0 && n < 1000; n++) @(negedge core_clk);
        check("busy end", 0, flash_busy);
        rd(0, a, d);
        xfer(1, 0, a, IDC);
        rd(0, a, CODE);
        xfer(1, 0, a, EXIT);
        rd(0, a, d);
        xfer(1, 0, a, ERASE);
        rd(0, a ^ 22'h008000, (a[15:0] ^ 16'h8000) ^ 16'h5a5a);
        for (n = 0; flash_busy !== 1'b0 && n < 1000; n++) @(negedge core_clk);
        rd(0, a, a[15:0] ^ 16'h5a5a);
        $display("test program done");
        b = a ^ 22'h200000;
        xfer(1, 0, b, IDC);
        xfer(1, 0, b, PROG);
        xfer(1, 0, b, ~d);
        @(negedge core_clk);
        req_reset = 1'b1;
        for (n = 0; ctl.reset_n !== 1'b0 && n < 20; n++) @(negedge core_clk);
        req_reset = 1'b0;
        check("busy in reset", 1, flash_busy);
        for (n = 0; ctl.reset_n === 1'b0 && n < 200; n++) @(negedge core_clk);
        check("reset pulse", 1, n >= 63);
        idle_wait();
        rd(0, b, b[15:0] ^ 16'h5a5a);
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
